// [rtl/padb_backend.sv]
// Digital back end of a 10-bit pipelined converter: phase generation, stage capture,
// alignment, error correction, format, output latching and a two-entry output buffer.
// Assumes the stage codes arrive synchronous to clk in the phase that drives each stage.
`timescale 1ns/100ps
`default_nettype none
`include "padb_cfg.svh"

module padb_backend (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Stage codes from the analog pipeline, stage 0 first
    input wire padb_pkg::padb_code_t stage_code [`PADB_STAGES],
    // Internal sampling phases
    output logic phi1,
    output logic phi2,
    // Format and output enable
    input wire logic output_format_select,
    input wire logic output_enable_n,
    // Sample stream
    output padb_pkg::padb_sample_t sample_word,
    output logic sample_word_oe,
    output logic sample_valid,
    input wire logic sample_ready
);
    padb_pkg::padb_phase_t phase_reg;
    padb_pkg::padb_phase_t phase_next;
    padb_pkg::padb_code_t cap_reg [`PADB_STAGES];
    padb_pkg::padb_code_t aligned [`PADB_STAGES];
    padb_pkg::padb_sum_t corr_sum;
    padb_pkg::padb_sample_t corr_clamped;
    padb_pkg::padb_sample_t corr_reg;
    padb_pkg::padb_sample_t latch1_reg;
    padb_pkg::padb_sample_t latch1_next;
    padb_pkg::padb_sample_t buf_reg [`PADB_BUF_DEPTH];
    logic [`PADB_WARMUP_W-1:0] warm_cnt_reg;
    logic buf_wr_reg;
    logic buf_rd_reg;
    logic [1:0] buf_cnt_reg;
    logic [1:0] buf_cnt_next;
    wire logic run;
    wire logic adv;
    wire logic warm;
    wire logic push;
    wire logic pop;
    wire logic buf_full;

    // A stall from the receiver that fills the buffer freezes the whole back end, phases included, so no word is dropped.
    assign buf_full = (buf_cnt_reg == 2'(`PADB_BUF_DEPTH));
    assign run = !buf_full;
    assign phi1 = (phase_reg == padb_pkg::PADB_PH_SAMPLE) && run;
    assign phi2 = (phase_reg == padb_pkg::PADB_PH_HOLD) && run;
    assign adv = phi2;
    assign warm = (warm_cnt_reg == `PADB_WARMUP);
    assign push = adv && warm;
    assign pop = sample_valid && sample_ready;

    always_comb begin
        phase_next = phase_reg;
        if (run) begin
            unique case (phase_reg)
                padb_pkg::PADB_PH_SAMPLE: phase_next = padb_pkg::PADB_PH_HOLD;
                padb_pkg::PADB_PH_HOLD: phase_next = padb_pkg::PADB_PH_SAMPLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            phase_reg <= padb_pkg::PADB_PH_SAMPLE;
        end else begin
            phase_reg <= phase_next;
        end
    end

    // Even stages take their code in the sampling phase, odd ones in the holding phase.
    // Stage k's code for a sample arrives k/2 sample cycles late. An odd stage is taken on the same edge that
    // steps the line, so it loses one step there and its line is one step shorter than its even neighbour's.
    for (genvar k = 0; k < `PADB_STAGES; k++) begin : g_stage
        wire logic cap_en;
        assign cap_en = (k % 2 == 0) ? phi1 : phi2;
        always_ff @(posedge clk) begin
            if (sys_rst) begin
                cap_reg[k] <= '0;
            end else if (cap_en) begin
                cap_reg[k] <= stage_code[k];
            end
        end
        padb_stage_delay #(
            .DEPTH((`PADB_LAST_STAGE - k) / 2)
        ) u_delay (
            .clk(clk),
            .sys_rst(sys_rst),
            .adv(adv),
            .d(cap_reg[k]),
            .q(aligned[k])
        );
    end

    // Overlapping two-bit codes add with one bit of overlap; the redundancy absorbs comparator error.
    always_comb begin
        corr_sum = '0;
        for (int k = 0; k < `PADB_MDAC_STAGES; k++) begin
            corr_sum = corr_sum + (padb_pkg::padb_sum_t'(aligned[k]) << (`PADB_LAST_STAGE - k));
        end
        corr_sum = corr_sum + padb_pkg::padb_sum_t'(aligned[`PADB_LAST_STAGE]);
    end

    // Illegal codes can push the sum past full scale; it saturates rather than wrapping.
    assign corr_clamped = corr_sum[`PADB_SUM_OVER] ? `PADB_FULL_SCALE : corr_sum[`PADB_SAMPLE_BITS-1:0];
    assign latch1_next = {corr_reg[`PADB_SAMPLE_BITS-1] ^ output_format_select,
                          corr_reg[`PADB_SAMPLE_BITS-2:0]};

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            corr_reg <= '0;
            latch1_reg <= '0;
        end else if (adv) begin
            corr_reg <= corr_clamped;
            latch1_reg <= latch1_next;
        end
    end

    // The warm-up count saturates, so one reset gives one discard window.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            warm_cnt_reg <= '0;
        end else if (adv && !warm) begin
            warm_cnt_reg <= warm_cnt_reg + `PADB_WARMUP_W'(1);
        end
    end

    // The buffer is the second output latch; its head drives the bus.
    assign buf_cnt_next = buf_cnt_reg + 2'(push) - 2'(pop);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            buf_wr_reg <= 1'b0;
            buf_rd_reg <= 1'b0;
            buf_cnt_reg <= '0;
            for (int i = 0; i < `PADB_BUF_DEPTH; i++) begin
                buf_reg[i] <= '0;
            end
        end else begin
            if (push) begin
                buf_reg[buf_wr_reg] <= latch1_reg;
                buf_wr_reg <= !buf_wr_reg;
            end
            if (pop) begin
                buf_rd_reg <= !buf_rd_reg;
            end
            buf_cnt_reg <= buf_cnt_next;
        end
    end

    assign sample_word = buf_reg[buf_rd_reg];
    assign sample_valid = (buf_cnt_reg != 2'h0);
    assign sample_word_oe = !output_enable_n;

    chk_phase_excl: assert property (@(posedge clk) disable iff (sys_rst) !(phi1 && phi2))
        else $error("Sampling and holding phases overlap.");
    chk_phase_alt: assert property (@(posedge clk) disable iff (sys_rst)
        phi1 |=> (phi2 || buf_full))
        else $error("Holding phase does not follow sampling phase.");
    chk_stall_freeze: assert property (@(posedge clk) disable iff (sys_rst)
        buf_full |=> $stable(phase_reg) && $stable(corr_reg))
        else $error("Pipeline moved while the buffer was full.");
    chk_corr_value: assert property (@(posedge clk) disable iff (sys_rst)
        adv |=> corr_reg == $past(corr_clamped))
        else $error("Corrected sample not latched on the sample edge.");
    chk_format_msb: assert property (@(posedge clk) disable iff (sys_rst)
        adv |=> (latch1_reg ^ $past(corr_reg)) == {$past(output_format_select), 9'h000})
        else $error("Format conversion changed more than the top bit.");
    chk_warmup_none: assert property (@(posedge clk) disable iff (sys_rst)
        (warm_cnt_reg < `PADB_WARMUP) |-> !push)
        else $error("Word pushed inside the power-up window.");
    chk_oe_follow: assert property (@(posedge clk) disable iff (sys_rst)
        sample_word_oe == !output_enable_n)
        else $error("Output enable does not follow the enable input.");
    chk_hold_word: assert property (@(posedge clk) disable iff (sys_rst)
        sample_valid && !sample_ready |=> sample_valid && $stable(sample_word))
        else $error("Stalled output word changed or vanished.");
    chk_push_lands: assert property (@(posedge clk) disable iff (sys_rst)
        push && !sample_valid |=> sample_valid && sample_word == $past(latch1_reg))
        else $error("Pushed word did not reach the bus on the next edge.");
    chk_steady_rate: assert property (@(posedge clk) disable iff (sys_rst)
        push ##1 !buf_full |-> ##1 phi2 || buf_full)
        else $error("Sample cadence broken without a stall.");
    chk_pop_step: assert property (@(posedge clk) disable iff (sys_rst)
        pop && !push |=> buf_cnt_reg == $past(buf_cnt_reg) - 2'h1)
        else $error("Buffer count did not drop after a pop.");
    chk_count_bound: assert property (@(posedge clk) disable iff (sys_rst)
        buf_cnt_reg <= 2'(`PADB_BUF_DEPTH))
        else $error("Buffer count beyond its depth.");
    chk_latch_store: assert property (@(posedge clk) disable iff (sys_rst)
        push |=> buf_reg[$past(buf_wr_reg)] == $past(latch1_reg))
        else $error("Second latch did not store the first latch word.");
    // A reset in mid-stream must empty the buffer at once, so no stale word leaks past the warm-up.
    chk_reset_idle: assert property (@(posedge clk) disable iff (sys_rst)
        $fell(sys_rst) |-> (!sample_valid) [*8])
        else $error("Word offered right after reset.");

    cov_first_word: cover property (@(posedge clk) disable iff (sys_rst) $rose(warm) ##[1:4] sample_valid);
    cov_buffer_full: cover property (@(posedge clk) disable iff (sys_rst) buf_full ##1 pop);
    cov_twos_comp: cover property (@(posedge clk) disable iff (sys_rst) push && output_format_select);
    cov_over_range: cover property (@(posedge clk) disable iff (sys_rst) adv && corr_sum[`PADB_SUM_OVER]);
    cov_reset_restart: cover property (@(posedge clk) $fell(sys_rst) ##[40:48] sample_valid);
endmodule
`default_nettype wire

// [rtl/padb_cfg.svh]
// Constants of the converter back end: widths, stage count, timing counts.
// Assumes inclusion by every design file that needs a figure.
`ifndef PADB_CFG_SVH
`define PADB_CFG_SVH

`define PADB_SAMPLE_BITS 10
`define PADB_CODE_BITS 2
`define PADB_STAGES 9
`define PADB_MDAC_STAGES 8
`define PADB_LAST_STAGE 8
// Sample-clock cycles from the sample to the word on the bus.
`define PADB_LATENCY 7
// Sample-clock cycles whose words are discarded after power-up.
`define PADB_WARMUP 5'h14
`define PADB_WARMUP_W 5
`define PADB_BUF_DEPTH 2
`define PADB_SUM_OVER 10
`define PADB_FULL_SCALE 10'h3FF

`endif

// [rtl/padb_pkg.sv]
// Types shared by the converter back end.
// Assumes padb_cfg.svh is on the include path.
`include "padb_cfg.svh"

package padb_pkg;
    typedef logic [`PADB_CODE_BITS-1:0] padb_code_t;
    typedef logic [`PADB_SAMPLE_BITS-1:0] padb_sample_t;
    typedef logic [`PADB_SAMPLE_BITS:0] padb_sum_t;
    // Sampling phase and holding phase of the internal two-phase clock.
    typedef enum logic {PADB_PH_SAMPLE, PADB_PH_HOLD} padb_phase_t;
endpackage

// [rtl/padb_stage_delay.sv]
// Per-stage digital delay line of the alignment network.
// Assumes adv is a one-cycle enable marking the end of each sample cycle.
`timescale 1ns/100ps
`default_nettype none
`include "padb_cfg.svh"

module padb_stage_delay #(
    parameter int DEPTH = 1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Shift control and data
    input wire logic adv,
    input wire padb_pkg::padb_code_t d,
    output padb_pkg::padb_code_t q
);
    generate
        if (DEPTH == 0) begin : g_pass
            assign q = d;
        end else begin : g_line
            padb_pkg::padb_code_t line_reg [DEPTH];
            always_ff @(posedge clk) begin
                if (sys_rst) begin
                    for (int i = 0; i < DEPTH; i++) begin
                        line_reg[i] <= '0;
                    end
                end else if (adv) begin
                    line_reg[0] <= d;
                    for (int i = 1; i < DEPTH; i++) begin
                        line_reg[i] <= line_reg[i-1];
                    end
                end
            end
            assign q = line_reg[DEPTH-1];
        end
    endgenerate
endmodule
`default_nettype wire

// [test/padb_capture.sv]
// Downstream capture model: takes sample words off the back end's stream handshake.
// Assumes the bench raises stall to hold off acceptance and to fill the two-entry buffer.
`timescale 1ns/100ps
`default_nettype none
`include "padb_cfg.svh"

module padb_capture (
    // Clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // Stream from the back end
    input wire logic sample_valid,
    input wire padb_pkg::padb_sample_t sample_word,
    output logic sample_ready,
    // Bench control and observation
    input wire logic stall,
    output padb_pkg::padb_sample_t last_word,
    output logic [31:0] word_count
);
    // Ready follows the inverse of stall one edge late, as a registered receiver would.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            sample_ready <= 1'b0;
            last_word <= 10'h000;
            word_count <= 32'h00000000;
        end else begin
            sample_ready <= !stall;
            // Only words offered by the back end count, so warm-up words are never kept.
            if (sample_valid && sample_ready) begin
                last_word <= sample_word;
                word_count <= word_count + 32'h00000001;
            end
        end
    end
endmodule
`default_nettype wire

// [test/pipelined_adc_digital_backend_bench.sv]
// Self-checking bench of the converter back end with a downstream capture model.
// Assumes the stage code inputs may be held constant, so any alignment gives the same word.
`timescale 1ns/100ps
`default_nettype none
`include "padb_cfg.svh"

module pipelined_adc_digital_backend_bench;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    padb_pkg::padb_code_t stage_code [`PADB_STAGES];
    logic phi1, phi2, output_format_select = 1'b0, output_enable_n = 1'b0;
    padb_pkg::padb_sample_t sample_word, last_word;
    logic sample_word_oe, sample_valid, sample_ready, stall = 1'b0;
    logic [31:0] word_count, base;
    int err_total = 0;
    int total_checks = 0;
    int n;
    typedef struct {logic [17:0] codes; logic fmt;} padb_row_t;
    padb_row_t rows [6] = '{'{18'h00000, 1'b0}, '{18'h3FFFF, 1'b0}, '{18'h20000, 1'b0},
                            '{18'h20000, 1'b1}, '{18'h15552, 1'b1}, '{18'h0A5A7, 1'b0}};

    always #2 clk = ~clk;

    padb_backend u_dut (.clk(clk), .sys_rst(sys_rst), .stage_code(stage_code), .phi1(phi1), .phi2(phi2),
        .output_format_select(output_format_select), .output_enable_n(output_enable_n),
        .sample_word(sample_word), .sample_word_oe(sample_word_oe), .sample_valid(sample_valid),
        .sample_ready(sample_ready));
    padb_capture u_cap (.clk(clk), .sys_rst(sys_rst), .sample_valid(sample_valid), .sample_word(sample_word),
        .sample_ready(sample_ready), .stall(stall), .last_word(last_word), .word_count(word_count));

    // Weighted sum of overlapping two-bit codes, saturated, top bit flipped for two's complement.
    function automatic padb_pkg::padb_sample_t exp_word(input logic [17:0] c, input logic fmt);
        logic [11:0] s;
        s = 12'h000;
        for (int k = 0; k < 8; k++) s = s + ({10'h000, c[17-2*k -: 2]} << (8 - k));
        s = s + {10'h000, c[1:0]};
        if (s > 12'h3FF) s = 12'h3FF;
        return {s[9] ^ fmt, s[8:0]};
    endfunction

    task automatic cmp_word(input padb_pkg::padb_sample_t got, input padb_pkg::padb_sample_t want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic cmp_bit(input logic got, input logic want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    task automatic cmp_count(input logic [31:0] got, input logic [31:0] want);
        total_checks++;
        if (got !== want) begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, want);
        end
    endtask

    // Counts holding phases until the first word is offered; a limit that runs out is a mismatch.
    task automatic warm_wait();
        n = 0;
        while (sample_valid !== 1'b1 && n < 200) begin
            @(posedge clk);
            #1;
            if (phi2 === 1'b1) n++;
            cmp_bit(phi1 & phi2, 1'b0);
        end
        cmp_bit(sample_valid, 1'b1);
        cmp_bit(n >= 20, 1'b1);
    endtask

    task automatic set_row(input padb_row_t r);
        for (int k = 0; k < `PADB_STAGES; k++) stage_code[k] <= r.codes[17-2*k -: 2];
        output_format_select <= r.fmt;
    endtask

    task automatic conclude();
        $display("checks %0d errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        foreach (stage_code[k]) stage_code[k] = 2'h1;
        repeat (19) @(posedge clk);
        #1;
        cmp_bit(sample_valid, 1'b0);
        cmp_bit(phi2, 1'b0);
        @(posedge clk) sys_rst <= 1'b0;
        warm_wait();
        // Every row holds its codes long enough to flush the pipeline, then the captured word is checked.
        foreach (rows[i]) begin
            @(posedge clk) set_row(rows[i]);
            repeat (40) @(posedge clk);
            #1;
            cmp_word(last_word, exp_word(rows[i].codes, rows[i].fmt));
        end
        cmp_word(exp_word(18'h20000, 1'b1), exp_word(18'h20000, 1'b0) ^ 10'h200);
        base = word_count;
        repeat (40) @(posedge clk);
        #1;
        cmp_count(word_count - base, 32'h14);
        @(posedge clk) output_enable_n <= 1'b1;
        #1;
        cmp_bit(sample_word_oe, 1'b0);
        base = word_count;
        repeat (10) @(posedge clk);
        #1;
        cmp_bit(word_count > base, 1'b1);
        @(posedge clk) output_enable_n <= 1'b0;
        #1;
        cmp_bit(sample_word_oe, 1'b1);
        // A receiver stall fills the buffer and must freeze the phases without losing words.
        @(posedge clk) stall <= 1'b1;
        repeat (12) @(posedge clk);
        #1;
        cmp_bit(phi1 | phi2, 1'b0);
        cmp_bit(sample_valid, 1'b1);
        base = word_count;
        @(posedge clk) stall <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        cmp_count(word_count - base, 32'h2);
        cmp_word(last_word, exp_word(rows[5].codes, rows[5].fmt));
        // Latency: stage 0 and stage 1 codes of one sample change in their own phases and must land together.
        @(posedge clk) set_row(rows[0]);
        repeat (40) @(posedge clk);
        #1;
        while (phi1 !== 1'b1) begin
            @(posedge clk);
            #1;
        end
        repeat (2) @(posedge clk);
        stage_code[0] <= 2'h2;
        @(posedge clk) stage_code[1] <= 2'h1;
        repeat (13) @(posedge clk);
        #1;
        cmp_word(last_word, exp_word(18'h00000, 1'b0));
        @(posedge clk);
        #1;
        cmp_word(last_word, exp_word(18'h24000, 1'b0));
        // A reset in mid-stream empties the buffer and opens a fresh discard window.
        @(posedge clk) sys_rst <= 1'b1;
        repeat (4) @(posedge clk);
        #1;
        cmp_bit(sample_valid, 1'b0);
        cmp_bit(phi2, 1'b0);
        @(posedge clk) sys_rst <= 1'b0;
        warm_wait();
        repeat (2) @(posedge clk);
        #1;
        cmp_word(last_word, exp_word(18'h24000, 1'b0));
        conclude();
    end

    // Watchdog sized well past the few hundred cycles the sequence needs.
    initial begin
        #20000;
        err_total++;
        conclude();
    end
endmodule
`default_nettype wire
